// [rtl/srp_pkg.sv]
// Constants, register map, states and carrier types of the standby/reset power sequencer.
// Assumes a single 40 MHz clock and a plain strobe-based register port.
package srp_pkg;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Clock and time base
   localparam int CLK_NS      = 25;
   localparam int TICK_NS     = 1000;
   localparam int TICK_CYCLES = (TICK_NS + CLK_NS - 1) / CLK_NS;
   localparam int TMR_W       = 16;

   // Delays in microseconds, as printed
   localparam logic [15:0] MIN_STBY_DEF_US   = 16'h2710;  // 10 ms
   localparam logic [15:0] MIN_STBY_FLOOR_US = 16'h0BB8;  // 3 ms
   localparam logic [15:0] BOOT_DLY_DEF_US   = 16'h2710;  // 10 ms
   localparam logic [15:0] BOOT_DLY_FLOOR_US = 16'h05DC;  // 1.5 ms
   localparam logic [15:0] CORE_SETTLE_US    = 16'h00C8;  // 200 us
   localparam logic [15:0] HW_INIT_US        = 16'h0082;  // 130 us
   localparam logic [15:0] CPU_SETTLE_US     = 16'h0032;  // 50 us
   localparam logic [15:0] RST_PULSE_US      = 16'h0014;  // 20 us

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Register map
   localparam int          ADDR_W       = 4;
   localparam int          DATA_W       = 32;
   localparam logic [3:0]  OFS_CTRL     = 4'h0;
   localparam logic [3:0]  OFS_MINSTBY  = 4'h4;
   localparam logic [3:0]  OFS_BOOTDLY  = 4'h8;
   localparam logic [3:0]  OFS_STATUS   = 4'hC;
   localparam int          CTRL_SLEEP   = 0;
   localparam int          CTRL_LPRS    = 1;
   localparam int          CTRL_LVS     = 2;
   localparam int          STAT_PWRON   = 5;
   localparam int          STAT_GRANT   = 6;
   localparam int          STAT_PEND    = 7;
   localparam logic [3:0]  SYNC_RST_VAL = 4'h1;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Types
   typedef enum logic [3:0] {
      ST_CORE_WAIT, ST_CORE_SETTLE, ST_HW_INIT, ST_BOOT, ST_RUN,
      ST_STOP, ST_STANDBY, ST_RST_PULSE, ST_EXT_RESET
   } srp_state_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } srp_req_t;

   typedef struct packed {
      logic lowVoltageSelect;
      logic lowpowerRegulatorSelect;
   } srp_ctrl_t;

endpackage : srp_pkg

// [rtl/srp_sequencer.sv]
// Standby entry/exit, supply settle and crash-recovery sequencer of the processor side.
// Assumes a power IC on powerOnRequest and an open-drain shared reset line; supply-good
// comparators, wake-up and the reset line arrive asynchronously.
//
// Summary of operation
// - Deep sleep selects Standby only with both regulator select bits cleared.
// - Power-on request drops in the same edge Standby is entered.
// - Minimum-standby timer starts on entry; no wake-up exit before it elapses.
// - Minimum-standby duration programmable, floor 3 ms, default 10 ms.
// - Wake-up after minimum standby exits Standby and raises power-on request.
// - Core supply good starts 200 us settle; internal reset held meanwhile (no settle after a shared reset: ST_EXT_RESET goes to ST_BOOT).
// - Leaving internal reset runs 130 us hardware initialisation (skipped when ST_EXT_RESET releases it straight into ST_BOOT).
// - Processor supply good starts settle; Run needs settle and init done (after a shared reset, ST_BOOT and Run follow without either).
// - Entering Run from Standby waits out boot-access delay before boot memory.
// - Boot-access delay programmable, default 10 ms after reset.
// - Boot-access delay may go down to 1.5 ms, no lower.
// - Shared active-low reset line, either side may pull it low.
// - Either watchdog expiring drives a low pulse onto the shared reset.
// - Watchdog pulse is generated from every state except the reset pulse and external reset states.
// - Shared reset rising starts the 10 ms boot-access delay.
//
// Added by the designer: the register offsets and the strobed register port.
module srp_sequencer
   import srp_pkg::*;
#(
   parameter logic [15:0] MIN_STBY_US = MIN_STBY_DEF_US,
   parameter logic [15:0] BOOT_DLY_US = BOOT_DLY_DEF_US,
   parameter logic [15:0] CORE_US     = CORE_SETTLE_US,
   parameter logic [15:0] INIT_US     = HW_INIT_US,
   parameter logic [15:0] CPU_US      = CPU_SETTLE_US,
   parameter logic [15:0] PULSE_US    = RST_PULSE_US,
   parameter int          TICKS       = TICK_CYCLES
) (
   input  wire logic              clk,
   input  wire logic              resetn,
   input  wire srp_req_t          busReq,
   output logic      [DATA_W-1:0] busRdata,
   input  wire logic              wakeupEvent,
   input  wire logic              coreSupplyGood,
   input  wire logic              cpuSupplyGood,
   input  wire logic              watchdogOneResetOut,
   input  wire logic              watchdogTwoResetOut,
   input  wire logic              sharedResetNIn,
   output logic                   sharedResetNOut,
   output logic                   sharedResetNOe,
   output logic                   powerOnRequest,
   output logic                   internalResetN,
   output logic                   runMode,
   output logic                   bootAccessGrant
);

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Input synchronisation
   logic [3:0] pinSync;
   logic       wakeS, coreGoodS, cpuGoodS, lineHighS;

   srp_sync #(
      .W       (4),
      .RST_VAL (SYNC_RST_VAL)
   ) uSync (
      .clk     (clk),
      .resetn  (resetn),
      .asyncIn ({wakeupEvent, coreSupplyGood, cpuSupplyGood, sharedResetNIn}),
      .syncOut (pinSync)
   );

   assign wakeS     = pinSync[3];
   assign coreGoodS = pinSync[2];
   assign cpuGoodS  = pinSync[1];
   assign lineHighS = pinSync[0];

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Timers
   logic              mainLoad;
   logic [TMR_W-1:0]  mainVal;
   logic              mainExp;
   logic              cpuExp;
   logic              cpuReady;

   srp_timer #(
      .TICKS (TICKS)
   ) uMainTimer (
      .clk     (clk),
      .resetn  (resetn),
      .load    (mainLoad),
      .loadVal (mainVal),
      .expired (mainExp)
   );

   srp_timer #(
      .TICKS (TICKS)
   ) uCpuTimer (
      .clk     (clk),
      .resetn  (resetn),
      .load    (!cpuGoodS),
      .loadVal (CPU_US),
      .expired (cpuExp)
   );

   assign cpuReady = cpuGoodS && cpuExp;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Helpers
   function automatic logic [15:0] clampFloor(input logic [15:0] v, input logic [15:0] f);
      return (v < f) ? f : v;
   endfunction : clampFloor

   function automatic logic isAwake(input srp_state_t s);
      return (s == ST_HW_INIT) || (s == ST_BOOT) || (s == ST_RUN) || (s == ST_STOP);
   endfunction : isAwake

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Register file
   srp_ctrl_t   ctrl_q, ctrl_d;
   logic [15:0] minStby_q, minStby_d;
   logic [15:0] bootDly_q, bootDly_d;
   logic        sleepReq_q, sleepReq_d;
   logic [31:0] rdata_d;
   srp_state_t  state_q, state_d;
   logic        pending_q, pending_d;

   always_comb begin
      ctrl_d     = ctrl_q;
      minStby_d  = minStby_q;
      bootDly_d  = bootDly_q;
      sleepReq_d = 1'b0;
      rdata_d    = '0;
      if (state_q == ST_EXT_RESET) begin
         ctrl_d    = '0;
         minStby_d = MIN_STBY_US;
         bootDly_d = BOOT_DLY_US;
      end else if (busReq.wr) begin
         case (busReq.addr)
            OFS_CTRL: begin
               ctrl_d.lowpowerRegulatorSelect = busReq.wdata[CTRL_LPRS];
               ctrl_d.lowVoltageSelect        = busReq.wdata[CTRL_LVS];
               sleepReq_d                     = busReq.wdata[CTRL_SLEEP];
            end
            OFS_MINSTBY: minStby_d = clampFloor(busReq.wdata[15:0], MIN_STBY_FLOOR_US);
            OFS_BOOTDLY: bootDly_d = clampFloor(busReq.wdata[15:0], BOOT_DLY_FLOOR_US);
            default: begin
            end
         endcase
      end
      if (busReq.rd) begin
         case (busReq.addr)
            OFS_CTRL:    rdata_d = {29'h0000000, ctrl_q.lowVoltageSelect,
                                    ctrl_q.lowpowerRegulatorSelect, 1'b0};
            OFS_MINSTBY: rdata_d = {16'h0000, minStby_q};
            OFS_BOOTDLY: rdata_d = {16'h0000, bootDly_q};
            OFS_STATUS:  rdata_d = {24'h000000, pending_q, bootAccessGrant, powerOnRequest,
                                    1'b0, state_q};
            default:     rdata_d = '0;
         endcase
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ctrl_q     <= '0;
         minStby_q  <= MIN_STBY_US;
         bootDly_q  <= BOOT_DLY_US;
         sleepReq_q <= 1'b0;
         busRdata   <= '0;
      end else begin
         ctrl_q     <= ctrl_d;
         minStby_q  <= minStby_d;
         bootDly_q  <= bootDly_d;
         sleepReq_q <= sleepReq_d;
         busRdata   <= rdata_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Sequencer
   logic watchdogHit;
   logic pwrOn_d, intRstN_d, run_d, grant_d, oe_d;

   assign watchdogHit = watchdogOneResetOut || watchdogTwoResetOut;

   always_comb begin
      state_d   = state_q;
      pending_d = pending_q;
      mainLoad  = 1'b0;
      mainVal   = CORE_US;
      if (watchdogHit && (state_q != ST_RST_PULSE) && (state_q != ST_EXT_RESET)) begin
         state_d   = ST_RST_PULSE;
         pending_d = 1'b0;
         mainLoad  = 1'b1;
         mainVal   = PULSE_US;
      end else if (!lineHighS && (state_q != ST_RST_PULSE) && (state_q != ST_EXT_RESET)) begin
         state_d   = ST_EXT_RESET;
         pending_d = 1'b0;
      end else begin
         case (state_q)
            ST_RUN: begin
               if (sleepReq_q) begin
                  if (!ctrl_q.lowpowerRegulatorSelect && !ctrl_q.lowVoltageSelect) begin
                     state_d   = ST_STANDBY;
                     pending_d = 1'b0;
                     mainLoad  = 1'b1;
                     mainVal   = minStby_q;
                  end else begin
                     state_d = ST_STOP;
                  end
               end
            end
            ST_STOP: begin
               if (wakeS) begin
                  state_d = ST_RUN;
               end
            end
            ST_STANDBY: begin
               if (wakeS) begin
                  pending_d = 1'b1;
               end
               if (mainExp && (pending_q || wakeS)) begin
                  state_d   = ST_CORE_WAIT;
                  pending_d = 1'b0;
               end
            end
            ST_CORE_WAIT: begin
               mainLoad = 1'b1;
               mainVal  = CORE_US;
               if (coreGoodS) begin
                  state_d = ST_CORE_SETTLE;
               end
            end
            ST_CORE_SETTLE: begin
               if (!coreGoodS) begin
                  state_d = ST_CORE_WAIT;
               end else if (mainExp) begin
                  state_d  = ST_HW_INIT;
                  mainLoad = 1'b1;
                  mainVal  = INIT_US;
               end
            end
            ST_HW_INIT: begin
               if (mainExp && cpuReady) begin
                  state_d  = ST_BOOT;
                  mainLoad = 1'b1;
                  mainVal  = bootDly_q;
               end
            end
            ST_BOOT: begin
               if (mainExp) begin
                  state_d = ST_RUN;
               end
            end
            ST_RST_PULSE: begin
               if (mainExp) begin
                  state_d = ST_EXT_RESET;
               end
            end
            ST_EXT_RESET: begin
               if (lineHighS) begin
                  state_d  = ST_BOOT;
                  mainLoad = 1'b1;
                  mainVal  = BOOT_DLY_US;
               end
            end
            default: begin
               state_d = ST_CORE_WAIT;
            end
         endcase
      end
   end

   always_comb begin
      pwrOn_d   = (state_d != ST_STANDBY);
      intRstN_d = isAwake(state_d);
      run_d     = (state_d == ST_BOOT) || (state_d == ST_RUN) || (state_d == ST_STOP);
      grant_d   = (state_d == ST_RUN) || (state_d == ST_STOP);
      oe_d      = (state_d == ST_RST_PULSE);
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_q         <= ST_CORE_WAIT;
         pending_q       <= 1'b0;
         powerOnRequest  <= 1'b1;
         internalResetN  <= 1'b0;
         runMode         <= 1'b0;
         bootAccessGrant <= 1'b0;
         sharedResetNOe  <= 1'b0;
         sharedResetNOut <= 1'b0;
      end else begin
         state_q         <= state_d;
         pending_q       <= pending_d;
         powerOnRequest  <= pwrOn_d;
         internalResetN  <= intRstN_d;
         runMode         <= run_d;
         bootAccessGrant <= grant_d;
         sharedResetNOe  <= oe_d;
         sharedResetNOut <= 1'b0;
      end
   end

endmodule : srp_sequencer

// [rtl/srp_sync.sv]
// Three-flop input synchroniser; an output changes once stages two and three agree.
// Assumes asynchronous inputs and a free-running clk.
module srp_sync
   import srp_pkg::*;
#(
   parameter int         W       = 4,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input  wire logic         clk,
   input  wire logic         resetn,
   input  wire logic [W-1:0] asyncIn,
   output logic      [W-1:0] syncOut
);

   logic [W-1:0] s1_q, s2_q, s3_q;
   logic [W-1:0] out_d;

   always_comb begin
      for (int i = 0; i < W; i++) begin
         out_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : syncOut[i];
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s1_q    <= RST_VAL;
         s2_q    <= RST_VAL;
         s3_q    <= RST_VAL;
         syncOut <= RST_VAL;
      end else begin
         s1_q    <= asyncIn;
         s2_q    <= s1_q;
         s3_q    <= s2_q;
         syncOut <= out_d;
      end
   end

endmodule : srp_sync

// [rtl/srp_timer.sv]
// Microsecond down-counter with its own prescaler; expired is a registered level.
// Assumes load values of at least one tick; load restarts the prescaler.
module srp_timer
   import srp_pkg::*;
#(
   parameter int TICKS = TICK_CYCLES
) (
   input  wire logic             clk,
   input  wire logic             resetn,
   input  wire logic             load,
   input  wire logic [TMR_W-1:0] loadVal,
   output logic                  expired
);

   logic [TMR_W-1:0] cnt_q, cnt_d;
   logic [7:0]       pre_q, pre_d;
   logic             exp_d;

   always_comb begin
      cnt_d = cnt_q;
      pre_d = pre_q;
      exp_d = expired;
      if (load) begin
         cnt_d = loadVal;
         pre_d = 8'(TICKS - 1);
         exp_d = (loadVal == '0);
      end else if (cnt_q != '0) begin
         if (pre_q == 8'h00) begin
            pre_d = 8'(TICKS - 1);
            cnt_d = cnt_q - 16'h0001;
            exp_d = (cnt_q == 16'h0001);
         end else begin
            pre_d = pre_q - 8'h01;
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cnt_q   <= '0;
         pre_q   <= '0;
         expired <= 1'b1;
      end else begin
         cnt_q   <= cnt_d;
         pre_q   <= pre_d;
         expired <= exp_d;
      end
   end

endmodule : srp_timer

// [tb/srp_pmic_model.sv]
// Behavioural power IC: regulators and the reset power cycle.
// Assumes the sequencer clock and a pulled-up shared reset wire.
module srp_pmic_model #(
   parameter int RAMP = 30,
   parameter int CYC  = 200
) (
   input  wire logic clk,
   input  wire logic powerOnRequest,
   input  wire logic sharedResetN,
   input  wire logic slow,
   output logic      coreSupplyGood,
   output logic      cpuSupplyGood,
   output logic      pullN,
   output logic      ioSupplyOn,
   output int        cycles
);
   timeunit 1ns;
   timeprecision 100ps;
   int   upCnt = 0;
   int   step  = 0;
   logic armed = 1'b1;
   logic powered;

   initial pullN = 1'b1;
   initial cycles = 0;
   assign powered = powerOnRequest && (step == 0 || step > CYC / 2);
   assign ioSupplyOn = 1'b1;
   assign coreSupplyGood = upCnt > (slow ? 4 * RAMP : RAMP);
   assign cpuSupplyGood = upCnt > (slow ? 6 * RAMP : 2 * RAMP);
   always @(posedge clk) begin
      if (powered) begin
         upCnt <= upCnt + 1;
      end else begin
         upCnt <= 0;
      end
      if (armed && !sharedResetN) begin
         armed <= 1'b0;
         step <= 1;
         pullN <= 1'b0;
         cycles <= cycles + 1;
      end else if (step == CYC) begin
         step <= 0;
         pullN <= 1'b1;
      end else if (step > 0) begin
         step <= step + 1;
      end else if (sharedResetN) begin
         armed <= 1'b1;
      end
   end
endmodule : srp_pmic_model

// [tb/srp_sequencer_props.sv]
// Port checker of the standby/reset power sequencer.
// Assumes srp_pkg and a pulse of three microseconds at two cycles each.
module srp_sequencer_props
   import srp_pkg::*;
#(
   parameter logic [15:0] MIN_STBY_US = MIN_STBY_DEF_US,
   parameter logic [15:0] BOOT_DLY_US = BOOT_DLY_DEF_US,
   parameter logic [15:0] CORE_US     = CORE_SETTLE_US,
   parameter logic [15:0] INIT_US     = HW_INIT_US,
   parameter logic [15:0] CPU_US      = CPU_SETTLE_US,
   parameter int          TICKS       = TICK_CYCLES
) (
   input wire logic     clk,
   input wire logic     resetn,
   input wire srp_req_t busReq,
   input wire logic     wakeupEvent,
   input wire logic     coreSupplyGood,
   input wire logic     cpuSupplyGood,
   input wire logic     watchdogOneResetOut,
   input wire logic     watchdogTwoResetOut,
   input wire logic     sharedResetNIn,
   input wire logic     sharedResetNOe,
   input wire logic     powerOnRequest,
   input wire logic     internalResetN,
   input wire logic     runMode,
   input wire logic     bootAccessGrant
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [31:0] lowCnt_q, coreCnt_q, hiCnt_q, cpuCnt_q, runCnt_q, lineCnt_q;
   logic [31:0] lowCnt_d, coreCnt_d, hiCnt_d, cpuCnt_d, runCnt_d, lineCnt_d;
   logic        wd;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Run-length counters
   always_comb begin
      lowCnt_d  = powerOnRequest ? 32'h0 : lowCnt_q + 32'h1;
      coreCnt_d = coreSupplyGood ? coreCnt_q + 32'h1 : 32'h0;
      hiCnt_d   = internalResetN ? hiCnt_q + 32'h1 : 32'h0;
      cpuCnt_d  = cpuSupplyGood ? cpuCnt_q + 32'h1 : 32'h0;
      runCnt_d  = runMode ? runCnt_q + 32'h1 : 32'h0;
      lineCnt_d = sharedResetNIn ? lineCnt_q + 32'h1 : 32'h0;
   end
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         {lowCnt_q, coreCnt_q, hiCnt_q, cpuCnt_q, runCnt_q, lineCnt_q} <= '0;
      end else begin
         {lowCnt_q, coreCnt_q, hiCnt_q} <= {lowCnt_d, coreCnt_d, hiCnt_d};
         {cpuCnt_q, runCnt_q, lineCnt_q} <= {cpuCnt_d, runCnt_d, lineCnt_d};
      end
   end
   assign wd = watchdogOneResetOut || watchdogTwoResetOut;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Properties
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);

   a_standby_hold: assert property ($rose(powerOnRequest) && !$past(wd)
      |-> lowCnt_q >= MIN_STBY_US * TICKS)
      else $error("power-on request rose before minimum standby");
   a_exit_cause: assert property ($rose(powerOnRequest) |-> $past(wakeupEvent, 3)
      || $past(watchdogOneResetOut) || $past(watchdogTwoResetOut))
      else $error("standby left without a wake-up");
   a_stop_keeps_req: assert property (busReq.wr && busReq.addr == OFS_CTRL
      && busReq.wdata[CTRL_SLEEP] && (busReq.wdata[CTRL_LPRS] || busReq.wdata[CTRL_LVS])
      |=> powerOnRequest [*4]) else $error("stop request dropped the power-on request");
   a_standby_entry: assert property (busReq.wr && busReq.addr == OFS_CTRL
      && busReq.wdata[2:0] == 3'h1 && bootAccessGrant |-> ##[1:3] !powerOnRequest)
      else $error("standby entry kept the power-on request");
   a_core_settle: assert property ($rose(internalResetN) |-> coreCnt_q >= CORE_US * TICKS)
      else $error("internal reset released before core settle");
   a_init_first: assert property ($rose(runMode) && $past(internalResetN) |->
      hiCnt_q >= INIT_US * TICKS && cpuCnt_q >= CPU_US * TICKS)
      else $error("run entered before init and processor settle");
   a_boot_delay: assert property ($rose(bootAccessGrant) |-> runCnt_q >= BOOT_DLY_US * TICKS)
      else $error("boot access granted early");
   a_grant_context: assert property (bootAccessGrant |-> runMode && internalResetN)
      else $error("boot access outside run");
   a_wdog_pulse: assert property (wd && lineCnt_q > 32'h8 && !sharedResetNOe
      |=> sharedResetNOe && !internalResetN) else $error("watchdog gave no reset pulse");
   a_pulse_width: assert property ($rose(sharedResetNOe) |-> sharedResetNOe [*6]
      ##[1:4] !sharedResetNOe) else $error("reset pulse width wrong");
   a_line_resets: assert property ($fell(sharedResetNIn) |-> ##[1:6] !internalResetN && !runMode)
      else $error("low shared reset did not reset the device");

   c_standby: cover property ($fell(powerOnRequest));
   c_pulse: cover property ($rose(sharedResetNOe));
   c_grant: cover property ($rose(bootAccessGrant));
endmodule : srp_sequencer_props

bind srp_sequencer srp_sequencer_props #(
   .MIN_STBY_US(MIN_STBY_US), .BOOT_DLY_US(BOOT_DLY_US), .CORE_US(CORE_US),
   .INIT_US(INIT_US), .CPU_US(CPU_US), .TICKS(TICKS)
) u_props (
   .clk(clk), .resetn(resetn), .busReq(busReq), .wakeupEvent(wakeupEvent),
   .coreSupplyGood(coreSupplyGood), .cpuSupplyGood(cpuSupplyGood),
   .watchdogOneResetOut(watchdogOneResetOut), .watchdogTwoResetOut(watchdogTwoResetOut),
   .sharedResetNIn(sharedResetNIn), .sharedResetNOe(sharedResetNOe),
   .powerOnRequest(powerOnRequest), .internalResetN(internalResetN), .runMode(runMode),
   .bootAccessGrant(bootAccessGrant)
);

// [tb/tb_srp_sequencer.sv]
// Self-checking bench of the standby/reset power sequencer.
// Assumes srp_pkg, the sequencer, its checker and the power IC model compiled first.
module tb_srp_sequencer
   import srp_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int T = 2;
   localparam int CYC = 200;

   logic              clk = 1'b0, resetn = 1'b0, wake = 1'b0, wd1 = 1'b0, wd2 = 1'b0;
   logic              btnN = 1'b1, slow = 1'b0, rdPend = 1'b0;
   srp_req_t          req = '0;
   logic [DATA_W-1:0] rdata;
   logic              coreGood, cpuGood, lineOut, lineOe, pwrReq, intRstN, runM, grant;
   logic              pullN, ioOn, line;
   int                pmicCycles, err_total = 0, compares = 0, seed = 50;
   logic [31:0]       expQ[$];

   always #12.5 clk = ~clk;
   assign line = !(lineOe && !lineOut) && pullN && btnN;

   srp_sequencer #(.MIN_STBY_US(16'h0014), .BOOT_DLY_US(16'h0014), .CORE_US(16'h000A),
      .PULSE_US(16'h0003), .TICKS(T)) dut (
      .clk(clk), .resetn(resetn), .busReq(req), .busRdata(rdata), .wakeupEvent(wake),
      .coreSupplyGood(coreGood), .cpuSupplyGood(cpuGood), .watchdogOneResetOut(wd1),
      .watchdogTwoResetOut(wd2), .sharedResetNIn(line), .sharedResetNOut(lineOut),
      .sharedResetNOe(lineOe), .powerOnRequest(pwrReq), .internalResetN(intRstN),
      .runMode(runM), .bootAccessGrant(grant));
   srp_pmic_model u_pmic (.clk(clk), .powerOnRequest(pwrReq),
      .sharedResetN(line), .slow(slow), .coreSupplyGood(coreGood), .cpuSupplyGood(cpuGood),
      .pullN(pullN), .ioSupplyOn(ioOn), .cycles(pmicCycles));

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Tasks
   task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
      compares++;
      if (s !== e) begin
         err_total++;
         $display("unexpected %s: expected %h, seen %h", what, e, s);
      end
   endtask : chk
   function automatic logic sel(input int w);
      case (w)
         0: return pwrReq;
         1: return grant;
         2: return line;
         default: return runM;
      endcase
   endfunction : sel
   task automatic waitSig(input int w, input logic v, input int lim, output int n);
      n = 0;
      while (sel(w) !== v && n < lim) begin
         @(posedge clk);
         n++;
      end
      chk("awaited output", v, sel(w));
   endtask : waitSig
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      req <= '0;
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      @(posedge clk);
      expQ.push_back(e);
      req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      req <= '0;
   endtask : rd
   task automatic give_verdict;
      $display("compares %0d, err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : give_verdict

   always @(posedge clk) begin
      rdPend <= req.rd;
      if (rdPend) begin
         chk("read data", expQ.pop_front(), rdata);
      end
   end

   initial begin
      repeat (40000) @(posedge clk);
      err_total++;
      $display("unexpected run length: expected under %0d cycles, seen more", 40000);
      give_verdict();
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Scenarios
   initial begin : main
      int          n, n0;
      logic [31:0] v, runWord;
      runWord = 32'h4 | 32'h1 << STAT_PWRON | 32'h1 << STAT_GRANT;
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      waitSig(1, 1'b1, 2000, n);
      rd(OFS_MINSTBY, 32'h14);
      rd(OFS_BOOTDLY, 32'h14);
      rd(4'h1, 32'h0);
      rd(OFS_STATUS, runWord);
      wr(OFS_MINSTBY, 32'h5);
      rd(OFS_MINSTBY, {16'h0, MIN_STBY_FLOOR_US});
      wr(OFS_BOOTDLY, 32'h0);
      rd(OFS_BOOTDLY, {16'h0, BOOT_DLY_FLOOR_US});
      v = {16'h0, MIN_STBY_FLOOR_US} + ($random(seed) & 32'h1FF);
      wr(OFS_MINSTBY, v);
      rd(OFS_MINSTBY, v);
      for (int i = 0; i < 2; i++) begin
         wr(OFS_CTRL, i == 0 ? 32'h3 : 32'h5);
         repeat (6) @(posedge clk);
         chk("stop request", 32'h1, pwrReq);
         wake <= 1'b1;
         repeat (8) @(posedge clk);
         wake <= 1'b0;
         rd(OFS_STATUS, runWord);
      end
      rd(OFS_CTRL, 32'h4);
      wr(OFS_CTRL, 32'h1);
      waitSig(0, 1'b0, 4, n);
      wake <= 1'b1;
      slow <= 1'b1;
      waitSig(0, 1'b1, v * T + 20, n);
      chk("standby span", 32'h1, n >= v * T - 2 && n <= v * T + 8);
      waitSig(3, 1'b1, 1000, n);
      wake <= 1'b0;
      slow <= 1'b0;
      waitSig(1, 1'b1, 4000, n);
      chk("boot delay", 32'h1, n >= BOOT_DLY_FLOOR_US * T - 2 && n <= BOOT_DLY_FLOOR_US * T + 4);
      for (int i = 0; i < 2; i++) begin
         if (i == 1) begin
            wr(OFS_CTRL, 32'h1);
            waitSig(0, 1'b0, 4, n);
         end
         n0 = pmicCycles;
         wd1 <= (i == 0);
         wd2 <= (i == 1);
         @(posedge clk);
         wd1 <= 1'b0;
         wd2 <= 1'b0;
         repeat (2) @(posedge clk);
         chk("reset drive", 32'h1, lineOe);
         chk("reset drive level", 32'h0, lineOut);
         waitSig(2, 1'b1, CYC + 50, n);
         waitSig(1, 1'b1, 200, n);
         chk("reset boot delay", 32'h1, n >= 20 * T && n <= 20 * T + 12);
         chk("power cycles", n0 + 1, pmicCycles);
         chk("io supply", 32'h1, ioOn);
         rd(OFS_MINSTBY, 32'h14);
      end
      n0 = pmicCycles;
      btnN <= 1'b0;
      repeat (CYC + 60) @(posedge clk);
      chk("internal reset", 32'h0, intRstN);
      btnN <= 1'b1;
      waitSig(1, 1'b1, 400, n);
      chk("power cycles", n0 + 1, pmicCycles);
      give_verdict();
   end
endmodule : tb_srp_sequencer
